/* File: verilog/rfgd_frame_gap_detector.sv */
// receive-side frame delimiter timing silence between bytes against a guard interval
`timescale 1ns/10ps
`include "rfgd_defs.svh"
module rfgd_frame_gap_detector
  import rfgd_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // received bytes
  input  wire rfgd_byte_t  rx_in,
  // delimited bytes and frame end
  output      rfgd_out_t   rx_out,
  output      logic        frame_end
);

  // ************************************************************
  // built-in guard interval table
  // ************************************************************

  // default interval in ms for a baud code
  function automatic logic [15:0] rfgd_default_ms(input logic [3:0] code);
    case (code)
      RFGD_B110:    rfgd_default_ms = 16'd350;
      RFGD_B150:    rfgd_default_ms = 16'd256;
      RFGD_B300:    rfgd_default_ms = 16'd128;
      RFGD_B600:    rfgd_default_ms = 16'd64;
      RFGD_B1200:   rfgd_default_ms = 16'd32;
      RFGD_B2400:   rfgd_default_ms = 16'd16;
      RFGD_B4800:   rfgd_default_ms = 16'd8;
      RFGD_B9600:   rfgd_default_ms = 16'd4;
      RFGD_B19200,
      RFGD_B28800,
      RFGD_B38400:  rfgd_default_ms = 16'd2;
      RFGD_B57600,
      RFGD_B115200: rfgd_default_ms = 16'd1;
      default:      rfgd_default_ms = 16'd1;
    endcase
  endfunction

  // ************************************************************
  // registers
  // ************************************************************

  logic [31:0] ctrl;
  logic [15:0] guard_ms;
  logic        eof_seen;
  logic [15:0] frame_count;

  // apb decode
  wire         apb_access = psel & penable;
  wire         wr_en      = apb_access & pwrite;
  wire         hit_ctrl   = (paddr == `RFGD_CTRL_ADDR);
  wire         hit_guard  = (paddr == `RFGD_GUARD_ADDR);
  wire         hit_status = (paddr == `RFGD_STATUS_ADDR);
  wire         hit_count  = (paddr == `RFGD_COUNT_ADDR);
  wire         hit_any    = hit_ctrl | hit_guard | hit_status | hit_count;
  wire         status_rd  = apb_access & ~pwrite & hit_status;

  logic        in_frame;
  logic [15:0] ms_count;

  // read mux, unmapped reads zero with error
  wire [31:0]  next_prdata = hit_ctrl   ? ctrl :
                             hit_guard  ? {16'h0000, guard_ms} :
                             hit_status ? {30'h0, eof_seen, in_frame} :
                             hit_count  ? {16'h0000, frame_count} : 32'h0000_0000;

  // pready is tied high: every transfer completes in its first access cycle,
  // and read data is loaded in the setup cycle so it already stands there
  assign pready  = 1'b1;
  assign pslverr = apb_access & ~hit_any;

  // apb data output flop
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata <= next_prdata;

  // writable configuration
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl     <= `RFGD_CTRL_RESET;
      guard_ms <= `RFGD_GUARD_RESET;
    end
    else if (wr_en)
    begin
      if (hit_ctrl)
        ctrl <= {24'h0, pwdata[7:0]};
      if (hit_guard)
        guard_ms <= pwdata[15:0];
    end

  // ************************************************************
  // guard interval selection
  // ************************************************************

  wire         mode_ok  = ctrl[`RFGD_CTRL_RTU] & ctrl[`RFGD_CTRL_SLAVE]
                          & ctrl[`RFGD_CTRL_MULTIDROP];
  wire         gap_on   = ctrl[`RFGD_CTRL_ENABLE] & mode_ok;
  wire [3:0]   baud     = ctrl[`RFGD_CTRL_BAUD_MSB:`RFGD_CTRL_BAUD_LSB];
  wire [15:0]  limit_ms = (guard_ms == 16'h0000) ? rfgd_default_ms(baud)
                                                 : guard_ms;

  // ************************************************************
  // millisecond time base and silence timer
  // ************************************************************

  localparam logic [13:0] TICK_LAST = 14'(`RFGD_TICK_CYCLES - 1);
  logic [13:0] tick_div;
  wire         ms_tick = (tick_div == TICK_LAST);
  wire         rx_byte = rx_in.valid;

  // the divider restarts with each byte, so frame end comes exactly limit_ms
  // ticks of silence after the last byte; a byte that lands on the tick edge
  // wins and restarts the count
  // divider restarts with each byte so the silence is measured from it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      tick_div <= 14'h0000;
    else if (rx_byte | ms_tick | ~in_frame)
      tick_div <= 14'h0000;
    else
      tick_div <= tick_div + 14'h0001;

  rfgd_state_t state;
  rfgd_state_t next_state;
  wire         gap_done   = in_frame & gap_on & ~rx_byte & ms_tick
                            & (ms_count + 16'h0001 >= limit_ms);
  wire [15:0]  next_count = rx_byte ? 16'h0000 :
                            ms_tick ? ms_count + 16'h0001 : ms_count;

  assign in_frame = (state == RFGD_FRAME);

  // state selection
  always_comb
  begin
    case (state)
      RFGD_IDLE:  next_state = rx_byte ? RFGD_FRAME : RFGD_IDLE;
      RFGD_FRAME: next_state = gap_done ? RFGD_IDLE : RFGD_FRAME;
      default:    next_state = RFGD_IDLE;
    endcase
  end

  // the silence counter keeps running while delimiting is off, so turning
  // delimiting on in the middle of a long silence ends the frame at the
  // next millisecond tick
  // state and silence counter
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state    <= RFGD_IDLE;
      ms_count <= 16'h0000;
    end
    else
    begin
      state    <= next_state;
      ms_count <= (next_state == RFGD_IDLE) ? 16'h0000 : next_count;
    end

  // ************************************************************
  // outputs and status
  // ************************************************************

  // byte passes with a first-of-message mark
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rx_out    <= '0;
      frame_end <= 1'b0;
    end
    else
    begin
      rx_out.valid <= rx_byte;
      rx_out.data  <= rx_in.data;
      rx_out.first <= rx_byte & ~in_frame;
      frame_end    <= gap_done;
    end

  // a status read that meets a new frame end in the same cycle leaves the flag set
  // sticky end-of-frame flag, cleared by reading status; a new end wins
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      eof_seen    <= 1'b0;
      frame_count <= 16'h0000;
    end
    else
    begin
      if (gap_done)
        eof_seen <= 1'b1;
      else if (status_rd)
        eof_seen <= 1'b0;
      if (gap_done)
        frame_count <= frame_count + 16'h0001;
    end

endmodule

/* File: verilog/rfgd_defs.svh */
// register offsets, field positions, reset values and timing counts of the frame gap detector
`ifndef RFGD_DEFS_SVH
`define RFGD_DEFS_SVH
// register byte addresses
`define RFGD_CTRL_ADDR      12'h000
`define RFGD_GUARD_ADDR     12'h004
`define RFGD_STATUS_ADDR    12'h008
`define RFGD_COUNT_ADDR     12'h00c
// control field positions
`define RFGD_CTRL_ENABLE    0
`define RFGD_CTRL_RTU       1
`define RFGD_CTRL_SLAVE     2
`define RFGD_CTRL_MULTIDROP 3
`define RFGD_CTRL_BAUD_LSB  4
`define RFGD_CTRL_BAUD_MSB  7
// reset values
`define RFGD_CTRL_RESET     32'h0000_0000
`define RFGD_GUARD_RESET    16'h0000
// time base: one millisecond at a 100 ns clock period
`define RFGD_CLK_PERIOD_NS  100
`define RFGD_TICK_NS        1000000
`define RFGD_TICK_CYCLES    (`RFGD_TICK_NS / `RFGD_CLK_PERIOD_NS)
`endif

/* File: verilog/rfgd_pkg.sv */
// types of the frame gap detector
package rfgd_pkg;
  // baud rate selection codes
  typedef enum logic [3:0] {
    RFGD_B110    = 4'h0,
    RFGD_B150    = 4'h1,
    RFGD_B300    = 4'h2,
    RFGD_B600    = 4'h3,
    RFGD_B1200   = 4'h4,
    RFGD_B2400   = 4'h5,
    RFGD_B4800   = 4'h6,
    RFGD_B9600   = 4'h7,
    RFGD_B19200  = 4'h8,
    RFGD_B28800  = 4'h9,
    RFGD_B38400  = 4'ha,
    RFGD_B57600  = 4'hb,
    RFGD_B115200 = 4'hc
  } rfgd_baud_t;

  // receiver states
  typedef enum logic [1:0] {
    RFGD_IDLE  = 2'b00,
    RFGD_FRAME = 2'b01
  } rfgd_state_t;

  // received byte from the serial receiver
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rfgd_byte_t;

  // delimited byte toward the message parser
  typedef struct packed {
    logic       valid;
    logic       first;
    logic [7:0] data;
  } rfgd_out_t;
endpackage

/* File: test/rfgd_chk_properties.sv */
// assertions of the frame gap detector
`timescale 1ns/10ps
module rfgd_chk
  import rfgd_pkg::*;
(
  // clock, reset and apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  // bytes and frame end
  input wire rfgd_byte_t  rx_in,
  input wire rfgd_out_t   rx_out,
  input wire logic        frame_end
);
  logic [3:0] ctrl;
  logic       open;
  int         quiet;
  // *****
  // shadow of mode bits, frame state and silence length
  // *****
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl  <= 4'h0;
      open  <= 1'b0;
      quiet <= 0;
    end
    else
    begin
      if (psel && penable && pwrite && paddr == 12'h000)
        ctrl <= pwdata[3:0];
      open  <= rx_in.valid | (open & !frame_end);
      quiet <= rx_in.valid ? 0 : quiet + 1;
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // *****
  // assertions
  // *****
  a_out_echo: assert property (rx_in.valid |=> rx_out.valid && rx_out.data == $past(rx_in.data))
    else $error("echoed byte wrong");
  a_out_idle: assert property (!rx_in.valid |=> !rx_out.valid)
    else $error("byte out without byte in");
  a_first_flag: assert property (rx_in.valid |=> rx_out.first == !($past(open) && !$past(frame_end)))
    else $error("first flag wrong");
  a_byte_holds: assert property (rx_in.valid |=> !frame_end)
    else $error("frame end right after byte");
  a_end_pulse: assert property (frame_end |=> !frame_end)
    else $error("frame end too long");
  a_end_open: assert property (frame_end |-> open)
    else $error("frame end with no frame");
  a_end_quiet: assert property (frame_end |-> quiet >= 9990)
    else $error("frame end before 1 ms of silence");
  a_end_mode: assert property (frame_end |-> ctrl[3:1] == 3'b111)
    else $error("frame end outside rtu slave multidrop");
  a_end_enable: assert property (frame_end |-> ctrl[0])
    else $error("frame end while disabled");
  c_end: cover property (frame_end);
  c_new: cover property (rx_in.valid && !open);
  c_err: cover property (pslverr);
endmodule
bind rfgd_frame_gap_detector rfgd_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .rx_in(rx_in), .rx_out(rx_out),
  .frame_end(frame_end));

/* File: test/rfgd_node.sv */
// model of the other nodes on the shared line
`timescale 1ns/10ps
module rfgd_node
  import rfgd_pkg::*;
(
  // clock
  input wire logic pclk,
  // bytes toward the detector
  output rfgd_byte_t rx_in
);
  initial rx_in = '0;
  // n back-to-back bytes; data then inverts so a stale value never matches
  task automatic send(input logic [7:0] b, input int n);
    int i;
    @(posedge pclk);
    for (i = 0; i < n; i++)
    begin
      rx_in <= '{1'b1, 8'(b + i)};
      @(posedge pclk);
    end
    rx_in <= '{1'b0, ~8'(b + n - 1)};
  endtask
endmodule

/* File: test/testbench.sv */
// self-checking bench of the frame gap detector
`timescale 1ns/10ps
module testbench;
  import rfgd_pkg::*;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  rfgd_byte_t  rx_in;
  rfgd_out_t   rx_out;
  logic        frame_end;
  logic [31:0] q;
  logic        e;
  int          at;
  int          n_mismatch  = 0;
  int          check_count = 0;
  always #50 pclk = ~pclk;
  rfgd_frame_gap_detector DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_in(rx_in),
    .rx_out(rx_out), .frame_end(frame_end));
  rfgd_node node (.pclk(pclk), .rx_in(rx_in));
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // compare one result
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // access phase: wait for pready at a rising edge, take the answer there
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
    begin
      n_mismatch++;
      $display("unexpected at %0t: no pready on apb transfer", $time);
      complete_run();
    end
  endtask
  // count cycles up to a frame end
  task automatic watch(input int lim);
    for (at = 0; at < lim; at++)
    begin
      @(posedge pclk);
      #1;
      if (frame_end === 1'b1)
        break;
    end
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    cmp(q, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    cmp(q, 32'h0);
    apb(1'b1, 12'h010, 32'h5);
    cmp({q[30:0], e}, 32'h1);
    node.send(8'h11, 1);
    #1;
    cmp(rx_out, {2'b11, 8'h11});
    node.send(8'h20, 3);
    #1;
    cmp(rx_out, {2'b10, 8'h22});
    apb(1'b1, 12'h000, 32'hce);
    watch(12000);
    cmp(at, 12000);
    apb(1'b1, 12'h000, 32'hc7);
    node.send(8'h30, 1);
    watch(12000);
    cmp(at, 12000);
    apb(1'b1, 12'h000, 32'hcf);
    node.send(8'h40, 2);
    watch(6000);
    cmp(at, 6000);
    node.send(8'h41, 1);
    #1;
    cmp(rx_out, {2'b10, 8'h41});
    watch(10020);
    cmp(at >= 9997 && at <= 10003, 1);
    apb(1'b0, 12'h008, 32'h0);
    cmp(q, 32'h2);
    apb(1'b0, 12'h008, 32'h0);
    cmp(q, 32'h0);
    apb(1'b1, 12'h004, 32'h2);
    node.send(8'h50, 1);
    #1;
    cmp(rx_out, {2'b11, 8'h50});
    watch(20020);
    cmp(at >= 19997 && at <= 20003, 1);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h8f);
    node.send(8'h60, 1);
    watch(20020);
    cmp(at >= 19997 && at <= 20003, 1);
    apb(1'b0, 12'h00c, 32'h0);
    cmp(q, 32'h3);
    complete_run();
  end
endmodule
